// ==== tb/ftc_far_model.sv ====
// Far-side model: converter results, fan drive level and four tach signals
`timescale 1ns/1ns
`default_nettype none
module ftc_far_model (
   input wire logic clk_in,
   input wire logic reset_in,
   output logic upd_out,
   output logic [7:0] low_out,
   output logic [7:0] hi_a_out,
   output logic [7:0] hi_b_out,
   output logic [7:0] hi_c_out,
   output logic [7:0] hi_d_out,
   output logic [3:0] tach_out,
   output logic pwm_out
);
   logic [7:0] v_q;
   logic [2:0] c_q;
   logic [4:0] t_q [4];
   // All results come from one counter so a torn read is easy to spot
   assign upd_out = c_q == 3'h6;
   assign low_out = v_q;
   assign hi_a_out = v_q;
   assign hi_b_out = v_q ^ 8'h11;
   assign hi_c_out = v_q ^ 8'h22;
   assign hi_d_out = v_q ^ 8'h33;
   // Fan i toggles every 6+i cycles, a full period of 12+2i
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         c_q <= 3'h0;
         v_q <= 8'h1b;
         tach_out <= 4'h0;
         pwm_out <= 1'b0;
         for (int i = 0; i < 4; i++) t_q[i] <= 5'h00;
      end else begin
         c_q <= (c_q == 3'h6) ? 3'h0 : c_q + 3'h1;
         pwm_out <= c_q[1];
         if (upd_out) v_q <= v_q + 8'h1b;
         for (int i = 0; i < 4; i++) begin
            t_q[i] <= (t_q[i] == 5'(5 + i)) ? 5'h00 : t_q[i] + 5'h01;
            if (t_q[i] == 5'(5 + i)) tach_out[i] <= !tach_out[i];
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/ftc_regs_asserts.sv ====
// Port-level checks for the fan tach configuration register slice
`timescale 1ns/1ns
`default_nettype none
module ftc_regs_chk #(
   parameter int NORMAL_CYC = 400,
   parameter int FAST_CYC = 100
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic lock_in,
   input wire logic out_of_limit_in,
   input wire logic second_fan_drive_in,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe_n_out,
   input wire logic [7:0] fan_pulse_count_out,
   input wire logic [3:0] tach_busy_out
);
   logic [7:0] cfg_q;
   logic [7:0] e_q;
   logic [3:0] h_q;
   logic f_q;
   logic p_q;
   // Shadow config rebuilt from bus traffic and lock_in, freeze state from bus traffic alone
   always_ff @(posedge clk_in) begin
      p_q <= rd_in && addr_in == 8'h77;
      if (p_q) e_q <= rdata_out;
      if (reset_in) begin
         cfg_q <= 8'h00;
         f_q <= 1'b0;
         h_q <= 4'h0;
      end else begin
         if (wr_in && addr_in == 8'h78 && !lock_in) cfg_q <= wdata_in;
         if (rd_in && addr_in == 8'h77) begin
            f_q <= 1'b1;
            h_q <= 4'h0;
         end
         // Clear on the last high byte, so a following reread is not judged frozen
         if (rd_in && addr_in[7:2] == 6'h19) begin
            h_q[addr_in[1:0]] <= 1'b1;
            if ((h_q | (4'h1 << addr_in[1:0])) == 4'hf) f_q <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_ext_reread;
      rd_in && addr_in == 8'h77 && f_q && !p_q;
   endsequence
   property p_ext_freeze;
      s_ext_reread |=> rdata_out == e_q;
   endproperty
   a_ext_freeze: assert property (p_ext_freeze)
      else $error("low bits changed while frozen");
   property p_rd_idle;
      !$past(rd_in) |-> rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   property p_pin_pwm;
      !$past(reset_in) && $stable(cfg_q) && !cfg_q[0]
         |-> shared_pin_out == $past(second_fan_drive_in) && !shared_pin_oe_n_out;
   endproperty
   a_pin_pwm: assert property (p_pin_pwm)
      else $error("pin not following fan drive");
   property p_pin_alert;
      !$past(reset_in) && $stable(cfg_q) && cfg_q[0]
         |-> !shared_pin_out && shared_pin_oe_n_out == !$past(out_of_limit_in);
   endproperty
   a_pin_alert: assert property (p_pin_alert)
      else $error("alert pin wrong");
   property p_cfg_read;
      rd_in && addr_in == 8'h78 |=> rdata_out == $past(cfg_q);
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("config readback wrong");
   property p_pulse_wr;
      wr_in && addr_in == 8'h7b |=> fan_pulse_count_out == $past(wdata_in);
   endproperty
   a_pulse_wr: assert property (p_pulse_wr)
      else $error("pulse count not written");
   property p_pulse_hold;
      !(wr_in && addr_in == 8'h7b) |=> $stable(fan_pulse_count_out);
   endproperty
   a_pulse_hold: assert property (p_pulse_hold)
      else $error("pulse count moved");
   property p_test_ro;
      rd_in && addr_in[7:1] == 7'h3f |=> rdata_out == 8'h00;
   endproperty
   a_test_ro: assert property (p_test_ro)
      else $error("test register not zero");
   property p_cont;
      cfg_q[4] && !tach_busy_out[0] |-> ##[1:4] tach_busy_out[0];
   endproperty
   a_cont: assert property (p_cont)
      else $error("continuous channel stayed idle");
endmodule
bind ftc_regs ftc_regs_chk #(.NORMAL_CYC(NORMAL_CYC), .FAST_CYC(FAST_CYC)) i_chk (
   .clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .lock_in,
   .out_of_limit_in, .second_fan_drive_in, .shared_pin_out, .shared_pin_oe_n_out,
   .fan_pulse_count_out, .tach_busy_out
);
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the fan tach configuration register slice
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} ftc_tb_row_s;
   logic clk_in, reset_in, wr_in, rd_in, lock_in, ool, upd, pwm;
   logic [7:0] addr_in, wdata_in, rdata_out, lo, ha, hb, hc, hd, l2, x, y;
   logic pin, oe_n, irq;
   logic [7:0] pcnt;
   logic [7:0] h0, h1, h2, h3;
   logic [3:0] tach, busy;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int pn = 0;
   int hcnt = 0;
   ftc_tb_row_s rows [11] = '{
      '{1'b0, 8'h7b, 8'h00, 8'h55},
      '{1'b0, 8'h78, 8'h00, 8'h00},
      '{1'b1, 8'h78, 8'h06, 8'h00},
      '{1'b0, 8'h78, 8'h00, 8'h06},
      '{1'b1, 8'h7e, 8'hff, 8'h00},
      '{1'b0, 8'h7e, 8'h00, 8'h00},
      '{1'b0, 8'h7f, 8'h00, 8'h00},
      '{1'b1, 8'h7b, 8'he4, 8'h00},
      '{1'b0, 8'h7b, 8'h00, 8'he4},
      '{1'b0, 8'h10, 8'h00, 8'h00},
      '{1'b0, 8'h61, 8'h00, 8'h00}
   };
   ftc_regs #(.NORMAL_CYC(400), .FAST_CYC(100)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .lock_in(lock_in), .conv_update_in(upd), .conv_low_bits_in(lo),
      .conv_hi_12v_in(ha), .conv_hi_remote_one_in(hb), .conv_hi_local_in(hc),
      .conv_hi_remote_two_in(hd), .out_of_limit_in(ool), .second_fan_drive_in(pwm),
      .fan_speed_input_in(tach), .shared_pin_out(pin), .shared_pin_oe_n_out(oe_n),
      .irq_out(irq), .fan_pulse_count_out(pcnt), .tach_busy_out(busy));
   ftc_far_model i_far (.clk_in(clk_in), .reset_in(reset_in), .upd_out(upd), .low_out(lo),
      .hi_a_out(ha), .hi_b_out(hb), .hi_c_out(hc), .hi_d_out(hd), .tach_out(tach),
      .pwm_out(pwm));
   task automatic stop_test();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One-cycle write; strobe drops on the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Data is only valid in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      v = rdata_out;
   endtask
   // Poll status until all bits of m are set, bounded
   task automatic wait_st(input logic [7:0] m);
      logic [7:0] s;
      s = 8'h00;
      pn = 0;
      while ((s & m) !== m && pn < 600) begin
         rd(8'h60, s);
         pn++;
      end
      chk(16'(s & m), 16'(m));
   endtask
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      reset_in = 1'b1;
      {wr_in, rd_in, lock_in, ool} = 4'h0;
      addr_in = 8'h00;
      wdata_in = 8'h00;
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      @(negedge clk_in);
      chk(16'(pcnt), 16'h0055);
      chk(16'({irq, oe_n}), 16'h0000);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a, x);
            chk(16'(x), 16'(rows[i].e));
         end
      end
      // Two full rounds so every period uses the new pulse counts
      wr(8'h61, 8'hff);
      wait_st(8'h0f);
      wr(8'h61, 8'hff);
      wait_st(8'h0f);
      chk(16'(irq), 16'h0000);
      wr(8'h62, 8'h0f);
      @(negedge clk_in);
      chk(16'(irq), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         rd(8'(8'h68 + 2 * i), x);
         rd(8'(8'h69 + 2 * i), y);
         chk({y, x}, 16'((i + 1) * (12 + 2 * i)));
      end
      wr(8'h61, 8'h0f);
      @(negedge clk_in);
      chk(16'(irq), 16'h0000);
      // Coherent 10-bit values while updates keep arriving
      rd(8'h77, l2);
      repeat (20) @(posedge clk_in);
      // A reread while frozen must give the same low bits, and re-arms the freeze
      rd(8'h77, x);
      chk(16'(x), 16'(l2));
      rd(8'h64, h0);
      rd(8'h65, h1);
      rd(8'h66, h2);
      rd(8'h67, h3);
      chk(16'({h0, l2[1:0]}), 16'({h0, h0[1:0]}));
      chk(16'({h1, l2[3:2]}), 16'({h0 ^ 8'h11, h0[3:2]}));
      chk(16'({h2, l2[5:4]}), 16'({h0 ^ 8'h22, h0[5:4]}));
      chk(16'({h3, l2[7:6]}), 16'({h0 ^ 8'h33, h0[7:6]}));
      repeat (20) @(posedge clk_in);
      rd(8'h77, x);
      chk(16'(x !== l2), 16'h0001);
      wr(8'h78, 8'h08);
      wr(8'h61, 8'h01);
      wait_st(8'h01);
      wr(8'h61, 8'h01);
      wait_st(8'h01);
      chk(16'(pn >= 30 && pn <= 70), 16'h0001);
      wr(8'h78, 8'h18);
      repeat (100) begin
         @(negedge clk_in);
         hcnt += busy[0];
      end
      chk(16'(hcnt >= 80), 16'h0001);
      lock_in <= 1'b1;
      wr(8'h78, 8'hff);
      rd(8'h78, x);
      chk(16'(x), 16'h0018);
      lock_in <= 1'b0;
      wr(8'h78, 8'h01);
      ool <= 1'b1;
      repeat (3) @(negedge clk_in);
      chk(16'({pin, oe_n}), 16'h0000);
      ool <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk(16'({pin, oe_n}), 16'h0001);
      stop_test();
   end
endmodule
`default_nettype wire

// ==== verilog/ftc_pkg.sv ====
// Shared constants, types and decode helpers for the fan tach config block
package ftc_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h61;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h62;
   localparam logic [7:0] ADDR_HI_BASE = 8'h64;
   localparam logic [7:0] ADDR_TACH_BASE = 8'h68;
   localparam logic [7:0] ADDR_EXT_LOW = 8'h77;
   localparam logic [7:0] ADDR_CFG3 = 8'h78;
   localparam logic [7:0] ADDR_PULSES = 8'h7b;
   localparam logic [7:0] ADDR_TEST1 = 8'h7e;
   localparam logic [7:0] ADDR_TEST2 = 8'h7f;

   // Values after reset
   localparam logic [7:0] CFG3_RESET = 8'h00;
   localparam logic [7:0] PULSES_RESET = 8'h55;
   localparam logic [7:0] TEST1_RESET = 8'h00;
   localparam logic [7:0] TEST2_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // Configuration 3 field positions
   localparam int CFG3_ALERT_BIT = 0;
   localparam int CFG3_FAST_BIT = 3;
   localparam int CFG3_CONT_LSB = 4;

   // Low-bit field positions in the extended result register
   localparam int EXT_12V_LSB = 0;
   localparam int EXT_REM1_LSB = 2;
   localparam int EXT_LOCAL_LSB = 4;
   localparam int EXT_REM2_LSB = 6;

   // Interrupt status layout
   localparam int IRQ_TACH_LSB = 0;
   localparam int IRQ_RESULT_BIT = 4;
   localparam int IRQ_DROP_BIT = 5;
   localparam logic [7:0] IRQ_USED_MASK = 8'h3f;

   // Measurement timing
   localparam int CLK_HZ = 10_000_000;
   localparam int TACH_NORMAL_MS = 1000;
   localparam int TACH_FAST_MS = 250;
   localparam int TACH_NORMAL_CYC = (CLK_HZ / 1000) * TACH_NORMAL_MS;
   localparam int TACH_FAST_CYC = (CLK_HZ / 1000) * TACH_FAST_MS;
   localparam int TIMER_W = 24;
   localparam int PERIOD_W = 16;
   localparam logic [15:0] PERIOD_MAX = 16'hffff;

   typedef enum logic [1:0] {
      TACH_IDLE = 2'b00,
      TACH_WAIT_FIRST = 2'b01,
      TACH_COUNT = 2'b10
   } ftc_tach_state_e;

   // Pulse-count field to number of pulses: 00=1, 01=2, 10=3, 11=4
   function automatic logic [2:0] ftc_pulses_decode(input logic [1:0] field);
      ftc_pulses_decode = {1'b0, field} + 3'h1;
   endfunction

endpackage

// ==== verilog/ftc_regs.sv ====
// Extended result, tach/alert configuration, pulse count and test registers
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module ftc_regs #(
   parameter int NORMAL_CYC = ftc_pkg::TACH_NORMAL_CYC,
   parameter int FAST_CYC = ftc_pkg::TACH_FAST_CYC
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic lock_in,
   input wire logic conv_update_in,
   input wire logic [7:0] conv_low_bits_in,
   input wire logic [7:0] conv_hi_12v_in,
   input wire logic [7:0] conv_hi_remote_one_in,
   input wire logic [7:0] conv_hi_local_in,
   input wire logic [7:0] conv_hi_remote_two_in,
   input wire logic out_of_limit_in,
   input wire logic second_fan_drive_in,
   input wire logic [3:0] fan_speed_input_in,
   output logic shared_pin_out,
   output logic shared_pin_oe_n_out,
   output logic irq_out,
   output logic [7:0] fan_pulse_count_out,
   output logic [3:0] tach_busy_out
);

   typedef struct packed {
      logic [7:0] ext_low;
      logic [3:0][7:0] hi;
      logic frozen;
      logic [3:0] hi_pending;
      logic [7:0] cfg3;
      logic [7:0] pulses;
      logic [7:0] test1;
      logic [7:0] test2;
      logic [7:0] irq_status;
      logic [7:0] irq_enable;
      logic [7:0] rdata;
      logic [23:0] timer;
      logic [3:0] start;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic pin;
      logic pin_oe_n;
   } ftc_regs_s;

   ftc_regs_s st_q;
   ftc_regs_s st_d;

   logic [3:0] tach_busy;
   logic [3:0] tach_done;
   logic [3:0][15:0] tach_period;
   logic [23:0] timer_limit;
   logic timer_wrap;
   logic [3:0] continuous;
   logic freeze_now;
   logic [3:0] hi_read;
   logic [3:0][7:0] conv_hi;
   logic [7:0] ev;

   localparam logic [23:0] NORMAL_LIMIT = 24'(NORMAL_CYC - 1);
   localparam logic [23:0] FAST_LIMIT = 24'(FAST_CYC - 1);

   // Address match helper for the banked high-byte and tach result registers
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] idx);
      addr_is = (a == base + idx);
   endfunction

   assign conv_hi[0] = conv_hi_12v_in;
   assign conv_hi[1] = conv_hi_remote_one_in;
   assign conv_hi[2] = conv_hi_local_in;
   assign conv_hi[3] = conv_hi_remote_two_in;

   // A read of the low-bit register in the update cycle also blocks that update,
   // otherwise the host would see old low bits paired with new high bytes
   assign freeze_now = st_q.frozen | (rd_in && addr_in == ftc_pkg::ADDR_EXT_LOW);

   // High-byte reads that release the freeze
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_hi_read
         assign hi_read[gi] = rd_in && addr_is(addr_in, ftc_pkg::ADDR_HI_BASE, 8'(gi));
      end
   endgenerate

   // Measurement rate and per-channel continuous selection
   assign timer_limit = st_q.cfg3[ftc_pkg::CFG3_FAST_BIT] ? FAST_LIMIT : NORMAL_LIMIT;
   assign timer_wrap = (st_q.timer >= timer_limit);
   assign continuous = st_q.cfg3[ftc_pkg::CFG3_CONT_LSB +: 4];

   // Hardware events for the interrupt status register
   always_comb begin
      ev = 8'h00;
      ev[ftc_pkg::IRQ_TACH_LSB +: 4] = tach_done;
      ev[ftc_pkg::IRQ_RESULT_BIT] = conv_update_in & ~freeze_now;
      ev[ftc_pkg::IRQ_DROP_BIT] = conv_update_in & freeze_now;
   end

   // Next-state logic: bus access, freeze, scheduler, sync, shared pin
   always_comb begin
      st_d = st_q;
      st_d.rdata = 8'h00;

      // Tach inputs come from pins: two flops before use
      st_d.sync1 = fan_speed_input_in;
      st_d.sync2 = st_q.sync1;

      // Converter results land only while not frozen
      if (conv_update_in && !freeze_now) begin
         st_d.ext_low = conv_low_bits_in;
         st_d.hi = conv_hi;
      end

      // Freeze bookkeeping
      if (rd_in && addr_in == ftc_pkg::ADDR_EXT_LOW) begin
         st_d.frozen = 1'b1;
         st_d.hi_pending = 4'hf;
      end else if (st_q.frozen) begin
         st_d.hi_pending = st_q.hi_pending & ~hi_read;
         if ((st_q.hi_pending & ~hi_read) == 4'h0) begin
            st_d.frozen = 1'b0;
         end
      end

      // Register writes
      if (wr_in) begin
         case (addr_in)
            ftc_pkg::ADDR_CFG3: begin
               if (!lock_in) begin
                  st_d.cfg3 = wdata_in;
               end
            end
            ftc_pkg::ADDR_PULSES: begin
               st_d.pulses = wdata_in;
            end
            ftc_pkg::ADDR_IRQ_ENABLE: begin
               st_d.irq_enable = wdata_in & ftc_pkg::IRQ_USED_MASK;
            end
            default: begin
               // Test registers are read-only; writes to them are dropped
            end
         endcase
      end

      // Sticky status: clear first, then set, so a same-cycle event survives
      if (wr_in && addr_in == ftc_pkg::ADDR_IRQ_CLEAR) begin
         st_d.irq_status = st_q.irq_status & ~wdata_in;
      end
      st_d.irq_status = st_d.irq_status | ev;

      // Register reads, data valid in the next cycle
      if (rd_in) begin
         case (addr_in)
            ftc_pkg::ADDR_EXT_LOW: st_d.rdata = st_q.ext_low;
            ftc_pkg::ADDR_CFG3: st_d.rdata = st_q.cfg3;
            ftc_pkg::ADDR_PULSES: st_d.rdata = st_q.pulses;
            ftc_pkg::ADDR_TEST1: st_d.rdata = st_q.test1;
            ftc_pkg::ADDR_TEST2: st_d.rdata = st_q.test2;
            ftc_pkg::ADDR_IRQ_STATUS: st_d.rdata = st_q.irq_status;
            ftc_pkg::ADDR_IRQ_ENABLE: st_d.rdata = st_q.irq_enable;
            default: begin
               st_d.rdata = 8'h00;
               for (int i = 0; i < 4; i++) begin
                  if (addr_is(addr_in, ftc_pkg::ADDR_HI_BASE, 8'(i))) begin
                     st_d.rdata = st_q.hi[i];
                  end
                  if (addr_is(addr_in, ftc_pkg::ADDR_TACH_BASE, 8'(2 * i))) begin
                     st_d.rdata = tach_period[i][7:0];
                  end
                  if (addr_is(addr_in, ftc_pkg::ADDR_TACH_BASE, 8'(2 * i + 1))) begin
                     st_d.rdata = tach_period[i][15:8];
                  end
               end
            end
         endcase
      end

      // Measurement timer; a rate change takes effect at once via the compare
      if (timer_wrap) begin
         st_d.timer = 24'h000000;
      end else begin
         st_d.timer = st_q.timer + 24'h000001;
      end

      // Start an idle channel at each period, or whenever idle in continuous mode
      for (int i = 0; i < 4; i++) begin
         st_d.start[i] = !tach_busy[i] && !st_q.start[i] &&
                         (timer_wrap || continuous[i]);
      end

      // Shared pin: alert is open drain, driven low only while out of limit
      if (st_q.cfg3[ftc_pkg::CFG3_ALERT_BIT]) begin
         st_d.pin = 1'b0;
         st_d.pin_oe_n = ~out_of_limit_in;
      end else begin
         st_d.pin = second_fan_drive_in;
         st_d.pin_oe_n = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
         st_q.ext_low <= ftc_pkg::RESULT_RESET;
         st_q.cfg3 <= ftc_pkg::CFG3_RESET;
         st_q.pulses <= ftc_pkg::PULSES_RESET;
         st_q.test1 <= ftc_pkg::TEST1_RESET;
         st_q.test2 <= ftc_pkg::TEST2_RESET;
         st_q.irq_status <= ftc_pkg::IRQ_RESET;
         st_q.irq_enable <= ftc_pkg::IRQ_RESET;
         st_q.pin_oe_n <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // Per-channel measurement engines
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tach
         ftc_tach_meas u_meas (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .start_in(st_q.start[gi]),
            .pulses_field_in(st_q.pulses[2 * gi +: 2]),
            .tach_in(st_q.sync2[gi]),
            .busy_out(tach_busy[gi]),
            .done_out(tach_done[gi]),
            .period_out(tach_period[gi])
         );
      end
   endgenerate

   // Outputs
   assign rdata_out = st_q.rdata;
   assign irq_out = |(st_q.irq_status & st_q.irq_enable);
   assign shared_pin_out = st_q.pin;
   assign shared_pin_oe_n_out = st_q.pin_oe_n;
   assign fan_pulse_count_out = st_q.pulses;
   assign tach_busy_out = tach_busy;

endmodule
`default_nettype wire

// ==== verilog/ftc_tach_meas.sv ====
// One tachometer channel: counts clock cycles across a chosen number of pulses
`timescale 1ns/1ns
`default_nettype none
module ftc_tach_meas (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic [1:0] pulses_field_in,
   input wire logic tach_in,
   output logic busy_out,
   output logic done_out,
   output logic [15:0] period_out
);

   typedef struct packed {
      ftc_pkg::ftc_tach_state_e state;
      logic tach_prev;
      logic [2:0] edges;
      logic [2:0] target;
      logic [15:0] count;
      logic [15:0] period;
      logic done;
   } ftc_tach_s;

   ftc_tach_s st_q;
   ftc_tach_s st_d;
   logic rise;

   assign rise = tach_in & ~st_q.tach_prev;

   // Stalled fan shows as a saturated period rather than hanging the channel
   always_comb begin
      st_d = st_q;
      st_d.tach_prev = tach_in;
      st_d.done = 1'b0;
      case (st_q.state)
         ftc_pkg::TACH_IDLE: begin
            if (start_in) begin
               st_d.state = ftc_pkg::TACH_WAIT_FIRST;
               st_d.target = ftc_pkg::ftc_pulses_decode(pulses_field_in);
               st_d.edges = 3'h0;
               st_d.count = 16'h0000;
            end
         end
         ftc_pkg::TACH_WAIT_FIRST: begin
            st_d.count = st_q.count + 16'h0001;
            if (rise) begin
               st_d.state = ftc_pkg::TACH_COUNT;
               st_d.count = 16'h0000;
            end else if (st_q.count == ftc_pkg::PERIOD_MAX) begin
               st_d.state = ftc_pkg::TACH_IDLE;
               st_d.period = ftc_pkg::PERIOD_MAX;
               st_d.done = 1'b1;
            end
         end
         ftc_pkg::TACH_COUNT: begin
            st_d.count = st_q.count + 16'h0001;
            if (rise) begin
               st_d.edges = st_q.edges + 3'h1;
               if (st_q.edges + 3'h1 == st_q.target) begin
                  st_d.state = ftc_pkg::TACH_IDLE;
                  st_d.period = st_q.count + 16'h0001;
                  st_d.done = 1'b1;
               end
            end else if (st_q.count == ftc_pkg::PERIOD_MAX) begin
               st_d.state = ftc_pkg::TACH_IDLE;
               st_d.period = ftc_pkg::PERIOD_MAX;
               st_d.done = 1'b1;
            end
         end
         default: begin
            st_d.state = ftc_pkg::TACH_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy_out = (st_q.state != ftc_pkg::TACH_IDLE);
   assign done_out = st_q.done;
   assign period_out = st_q.period;

endmodule
`default_nettype wire
